//--- rtl/iaru_core.sv
/*
 shader core end: takes one command, encodes it onto the link with the
 ray operand layout, waits for the answer and hands it back.
 assumes: the device answers each accepted request exactly once.
*/
`default_nettype none
module iaru_core (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// link to the operand unit
	iaru_if.core                        link,
	// command side
	input  wire logic                   cmdValid,
	output logic                        cmdReady,
	input  wire iaru_pkg::iaru_op_t     cmdOp,
	input  wire iaru_pkg::iaru_flags_t  cmdFlags,
	input  wire logic [3:0][31:0]       cmdAddr,
	input  wire logic [31:0]            cmdData,
	input  wire iaru_pkg::iaru_ray_t    cmdRay,
	// result side
	output logic                        resValid,
	output logic [3:0][31:0]            resData
);
	typedef enum logic [1:0] {IDLE, ISSUE, WAIT} iaru_cst_t;

	typedef struct packed {
		iaru_cst_t             st;
		iaru_pkg::iaru_op_t    op;
		iaru_pkg::iaru_flags_t flags;
		logic [3:0]            cnt;
		logic [11:0][31:0]     vec;
		logic [1:0][31:0]      node;
		logic [31:0]           extent;
		logic [2:0][31:0]      org;
		logic [2:0][31:0]      dir;
		logic [2:0][31:0]      inv;
		logic [31:0]           data;
		logic                  resValid;
		logic [3:0][31:0]      resData;
	} iaru_cstate_t;

	iaru_cstate_t stateReg, stateNext;
	logic [3:0]   b;
	logic         isRay, is64;

	assign cmdReady = (stateReg.st == IDLE);
	assign link.reqValid = (stateReg.st == ISSUE);
	assign link.op = stateReg.op;
	assign link.flags = stateReg.flags;
	assign link.addrCount = stateReg.cnt;
	assign link.addrVec = stateReg.vec;
	assign link.grpNode = stateReg.node;
	assign link.grpExtent = stateReg.extent;
	assign link.grpOrigin = stateReg.org;
	assign link.grpDir = stateReg.dir;
	assign link.grpInv = stateReg.inv;
	assign link.dataWord = stateReg.data;
	assign resValid = stateReg.resValid;
	assign resData = stateReg.resData;

	always_comb begin
		stateNext = stateReg;
		stateNext.resValid = 1'b0;
		is64 = (cmdOp == iaru_pkg::OP_RAY64);
		isRay = is64 || (cmdOp == iaru_pkg::OP_RAY32);
		b = is64 ? 4'h2 : 4'h1;
		case (stateReg.st)
			IDLE: begin
				if (cmdValid) begin
					stateNext = '0;
					stateNext.st = ISSUE;
					stateNext.op = cmdOp;
					stateNext.flags = cmdFlags;
					stateNext.data = cmdData;
					stateNext.resData = stateReg.resData;
					if (!isRay) begin
						stateNext.vec[3:0] = cmdAddr;
						stateNext.cnt = 4'h4;
					end else begin
						stateNext.flags.channelMask = iaru_pkg::RAY_CHMASK;
						stateNext.flags.halfReturnFlag = 1'b0;
						stateNext.flags.shortDescriptorFlag = 1'b1;
						stateNext.flags.unnormCoordFlag = 1'b1;
						stateNext.flags.dimensionField = iaru_pkg::DIM_1D;
						stateNext.flags.lodWarnFlag = 1'b0;
						stateNext.flags.residencyStatusFlag = 1'b0;
						if (is64)
							stateNext.cnt = cmdFlags.halfAddressFlag ?
								iaru_pkg::RAY64_HALF :
								iaru_pkg::RAY64_FULL;
						else
							stateNext.cnt = cmdFlags.halfAddressFlag ?
								iaru_pkg::RAY32_HALF :
								iaru_pkg::RAY32_FULL;
						if (cmdFlags.nonseqAddressMode) begin
							stateNext.node = cmdRay.ptr;
							stateNext.extent = cmdRay.extent;
							stateNext.org = cmdRay.org;
							for (int k = 0; k < 3; k++) begin
								stateNext.dir[k] = cmdFlags.halfAddressFlag ?
									{cmdRay.inv[k][15:0], cmdRay.dir[k][15:0]} :
									cmdRay.dir[k];
								stateNext.inv[k] = cmdFlags.halfAddressFlag ?
									32'h0 : cmdRay.inv[k];
							end
						end else begin
							stateNext.vec[0] = cmdRay.ptr[31:0];
							if (is64)
								stateNext.vec[1] = cmdRay.ptr[63:32];
							stateNext.vec[b] = cmdRay.extent;
							for (int k = 0; k < 3; k++) begin
								stateNext.vec[b + 4'(1 + k)] = cmdRay.org[k];
								if (cmdFlags.halfAddressFlag) begin
									// inverse in the upper half
									stateNext.vec[b + 4'(4 + k)] =
										{cmdRay.inv[k][15:0],
										cmdRay.dir[k][15:0]};
								end else begin
									stateNext.vec[b + 4'(4 + k)] = cmdRay.dir[k];
									stateNext.vec[b + 4'(7 + k)] = cmdRay.inv[k];
								end
							end
						end
					end
				end
			end
			ISSUE: begin
				if (link.reqReady)
					stateNext.st = WAIT;
			end
			WAIT: begin
				if (link.rspValid) begin
					stateNext.st = IDLE;
					stateNext.resValid = 1'b1;
					stateNext.resData = link.rspData;
				end
			end
			default: stateNext.st = IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end
endmodule
`default_nettype wire

//--- rtl/iaru_device.sv
/*
 operand unit end: decodes image requests, runs the atomics on a local
 word memory, answers queries and ray node tests one cycle later.
 assumes: the core keeps the ray encoding restrictions; the texture
 pipe fills memory through the fill port.
// Summary of operation
// - bitwise atomics store and/or/xor, return old
// - increment wraps to zero at operand
// - decrement wraps to operand at zero
// - resource info returns mips, depth, height, width
// - multisample load fetches samples by fragment index
// - box node returns children sorted by time
// - triangle node returns time and triangle id
// - full 32-bit pointer ray uses eleven registers
// - half flag packs dir pairs, eight registers
// - nonsequential mode takes separate operand groups
// - encoder sets full mask, short descriptor, full return
// - encoder sets unnormalized, clears dimension, warn, residency
// - encoding restrictions not checked by device
// - ray ops ignore order, return in order
// - 64-bit pointer ray uses twelve registers
// - 64-bit half form uses nine registers
// - lod query returns clamped then raw
// - gather returns 2x2 footprint components
// - level-zero variants sample mip zero only
// - gradient-16 variants take half derivatives
// - compare variants apply depth compare filter
*/
`default_nettype none
module iaru_device #(
	parameter int MEM_DEPTH = iaru_pkg::MEM_DEPTH
) (
	// clock and reset
	input  wire logic           clk,
	input  wire logic           reset,
	// shader core side
	iaru_if.dev                 link,
	// texture pipe side
	input  wire logic           memFillEn,
	input  wire logic [31:0]    memFillAddr,
	input  wire logic [31:0]    memFillData,
	output logic                rayValid,
	output iaru_pkg::iaru_ray_t rayOut
);
	localparam int AW = $clog2(MEM_DEPTH);

	if (MEM_DEPTH < iaru_pkg::TEX_BASE + iaru_pkg::MIP_LEVELS *
		iaru_pkg::LEVEL_STRIDE) begin : gBadDepth
		$error("memory too small for the texture map");
	end

	typedef struct packed {
		logic                rspValid;
		logic [3:0][31:0]    rspData;
		logic                rayValid;
		iaru_pkg::iaru_ray_t ray;
	} iaru_dstate_t;

	iaru_dstate_t stateReg, stateNext;
	logic [31:0] mem [MEM_DEPTH];

	logic [11:0][31:0]   v;
	iaru_pkg::iaru_ray_t r;
	iaru_pkg::iaru_flags_t f;
	logic [3:0]          b;
	logic                take, isAtomic;
	logic [AW-1:0]       aAddr, na, ta;
	logic [31:0]         oldVal, newVal, w;
	logic [3:0][31:0]    tm, cp, box, tx, rsp;
	logic [1:0]          rk, lvl;
	logic signed [9:0]   lodRaw;

	function automatic logic [31:0] itof(input logic signed [9:0] n);
		logic [32:0] m;
		int p;
		begin
			m = {23'h0, n < 0 ? 10'(-n) : 10'(n)};
			p = 0;
			for (int i = 0; i < 10; i++) begin
				if (m[i])
					p = i;
			end
			m = m << (23 - p);
			itof = (n == 0) ? 32'h0 :
				{n < 0, 8'(127 + p), m[22:0]};
		end
	endfunction

	// fill has the memory port this cycle, so requests wait
	assign link.reqReady = !memFillEn;
	assign take = link.reqValid && link.reqReady;
	assign link.rspValid = stateReg.rspValid;
	assign link.rspData = stateReg.rspData;
	assign rayValid = stateReg.rayValid;
	assign rayOut = stateReg.ray;

	always_comb begin
		v = link.addrVec;
		f = link.flags;
		r = '0;
		rk = 2'h0;
		b = (link.op == iaru_pkg::OP_RAY64) ? 4'h2 : 4'h1;
		// flags other than half and nonseq are not checked here
		if (!f.nonseqAddressMode) begin
			r.ptr = (link.op == iaru_pkg::OP_RAY64) ? {v[1], v[0]} :
				{32'h0, v[0]};
			r.extent = v[b];
			for (int k = 0; k < 3; k++) begin
				r.org[k] = v[b + 4'(1 + k)];
				if (f.halfAddressFlag) begin
					r.dir[k] = {16'h0, v[b + 4'(4 + k)][15:0]};
					r.inv[k] = {16'h0, v[b + 4'(4 + k)][31:16]};
				end else begin
					r.dir[k] = v[b + 4'(4 + k)];
					r.inv[k] = v[b + 4'(7 + k)];
				end
			end
		end else begin
			r.ptr = (link.op == iaru_pkg::OP_RAY64) ?
				{link.grpNode[1], link.grpNode[0]} :
				{32'h0, link.grpNode[0]};
			r.extent = link.grpExtent;
			r.org = link.grpOrigin;
			for (int k = 0; k < 3; k++) begin
				if (f.halfAddressFlag) begin
					r.dir[k] = {16'h0, link.grpDir[k][15:0]};
					r.inv[k] = {16'h0, link.grpDir[k][31:16]};
				end else begin
					r.dir[k] = link.grpDir[k];
					r.inv[k] = link.grpInv[k];
				end
			end
		end

		// node fetch: children behind the times beyond the ray extent miss
		na = AW'(r.ptr) & ~AW'(1);
		for (int i = 0; i < 4; i++) begin
			tm[i] = mem[na + AW'(4 + i)];
			tm[i] = (tm[i] > r.extent) ? iaru_pkg::INF_TIME : tm[i];
			cp[i] = (tm[i] == iaru_pkg::INF_TIME) ? iaru_pkg::MISS_PTR :
				mem[na + AW'(i)];
		end
		box = '0;
		for (int i = 0; i < 4; i++) begin
			rk = 2'h0;
			for (int j = 0; j < 4; j++) begin
				if (tm[j] < tm[i] || (tm[j] == tm[i] && j < i))
					rk = 2'(rk + 2'h1);
			end
			box[rk] = cp[i];
		end

		// atomics: read and write of the word in one edge
		aAddr = AW'(v[0]);
		oldVal = mem[aAddr];
		isAtomic = link.op inside {iaru_pkg::OP_CONJ, iaru_pkg::OP_DISJ,
			iaru_pkg::OP_EXCL, iaru_pkg::OP_WRAP_INC,
			iaru_pkg::OP_WRAP_DEC};
		case (link.op)
			iaru_pkg::OP_CONJ: newVal = oldVal & link.dataWord;
			iaru_pkg::OP_DISJ: newVal = oldVal | link.dataWord;
			iaru_pkg::OP_EXCL: newVal = oldVal ^ link.dataWord;
			iaru_pkg::OP_WRAP_INC: newVal = (oldVal >= link.dataWord) ?
				32'h0 : 32'(oldVal + 32'h1);
			iaru_pkg::OP_WRAP_DEC: newVal = (oldVal == 32'h0 ||
				oldVal > link.dataWord) ? link.dataWord :
				32'(oldVal - 32'h1);
			default: newVal = oldVal;
		endcase

		// level from the gradient exponent, half or single precision
		lodRaw = f.grad16 ? $signed({5'h0, v[2][14:10]}) -
			iaru_pkg::F16_BIAS : $signed({2'h0, v[2][30:23]}) -
			iaru_pkg::F32_BIAS;
		if (lodRaw < 0)
			lvl = 2'h0;
		else if (lodRaw > 10'(iaru_pkg::MIP_LEVELS - 1))
			lvl = 2'(iaru_pkg::MIP_LEVELS - 1);
		else
			lvl = lodRaw[1:0];
		if (f.levelZero && link.op != iaru_pkg::OP_LOD)
			lvl = 2'h0;
		for (int q = 0; q < 4; q++) begin
			ta = AW'(iaru_pkg::TEX_BASE + 32'(lvl) *
				iaru_pkg::LEVEL_STRIDE + ((v[1] + 32'(q / 2)) <<
				(iaru_pkg::TEX_LOG2W - 32'(lvl))) + v[0] + 32'(q % 2));
			tx[q] = mem[ta];
			if (f.depthCompare)
				tx[q] = (tx[q] <= v[3]) ? iaru_pkg::ONE_F : 32'h0;
		end

		w = (v[0] >= 32'(iaru_pkg::TEX_LOG2W)) ? 32'h1 :
			32'(1 << (iaru_pkg::TEX_LOG2W - 32'(v[0])));
		rsp = '0;
		case (link.op)
			iaru_pkg::OP_RESINFO:
				rsp = {32'(iaru_pkg::MIP_LEVELS), 32'h1, w, w};
			iaru_pkg::OP_MSAA: begin
				for (int i = 0; i < 4; i++) begin
					ta = AW'(iaru_pkg::MSAA_BASE + (((v[1] <<
						iaru_pkg::TEX_LOG2W) + v[0]) << 2) +
						((v[2] + 32'(i)) & 32'h3));
					rsp[i] = f.channelMask[i] ? mem[ta] : 32'h0;
				end
			end
			iaru_pkg::OP_RAY32, iaru_pkg::OP_RAY64:
				rsp = r.ptr[iaru_pkg::NODE_TRI_BIT] ?
					{64'h0, mem[na + AW'(1)], (mem[na] > r.extent) ?
					iaru_pkg::INF_TIME : mem[na]} : box;
			iaru_pkg::OP_LOD:
				rsp = {64'h0, itof(lodRaw), itof({8'h0, lvl})};
			iaru_pkg::OP_SAMPLE: rsp = {96'h0, tx[0]};
			iaru_pkg::OP_GATHER: rsp = tx;
			default: rsp = {96'h0, oldVal};
		endcase

		// single outstanding answer, so ray results are always in order
		stateNext = stateReg;
		stateNext.rspValid = take;
		stateNext.rayValid = take && (link.op == iaru_pkg::OP_RAY32 ||
			link.op == iaru_pkg::OP_RAY64);
		if (take) begin
			stateNext.rspData = rsp;
			if (stateNext.rayValid)
				stateNext.ray = r;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	// no reset on the array; it is storage, not control
	always_ff @(posedge clk) begin
		if (take && isAtomic)
			mem[aAddr] <= newVal;
		else if (memFillEn)
			mem[AW'(memFillAddr)] <= memFillData;
	end
endmodule
`default_nettype wire

//--- rtl/iaru_if.sv
/*
 interface joining the shader core end and the operand unit end.
 assumes: one clock; one request outstanding at a time.
*/
`default_nettype none
interface iaru_if;
	logic                  reqValid;
	logic                  reqReady;
	iaru_pkg::iaru_op_t    op;
	iaru_pkg::iaru_flags_t flags;
	logic [3:0]            addrCount;
	logic [11:0][31:0]     addrVec;
	logic [1:0][31:0]      grpNode;
	logic [31:0]           grpExtent;
	logic [2:0][31:0]      grpOrigin;
	logic [2:0][31:0]      grpDir;
	logic [2:0][31:0]      grpInv;
	logic [31:0]           dataWord;
	logic                  rspValid;
	logic [3:0][31:0]      rspData;

	modport core (
		output reqValid, op, flags, addrCount, addrVec, grpNode,
		output grpExtent, grpOrigin, grpDir, grpInv, dataWord,
		input  reqReady, rspValid, rspData
	);
	modport dev (
		input  reqValid, op, flags, addrCount, addrVec, grpNode,
		input  grpExtent, grpOrigin, grpDir, grpInv, dataWord,
		output reqReady, rspValid, rspData
	);
endinterface
`default_nettype wire

//--- rtl/iaru_pkg.sv
/*
 package: opcodes, encoding flags, ray operand layout and the fixed
 memory map of the img_atomic_bitwise_conj ray operand unit.
 assumes: shared by the core end, the device end and the interface.
*/
`default_nettype none
package iaru_pkg;
	typedef enum logic [3:0] {
		OP_CONJ, OP_DISJ, OP_EXCL, OP_WRAP_INC, OP_WRAP_DEC,
		OP_RESINFO, OP_MSAA, OP_RAY32, OP_RAY64, OP_LOD,
		OP_SAMPLE, OP_GATHER
	} iaru_op_t;

	typedef struct packed {
		logic       halfAddressFlag;
		logic       nonseqAddressMode;
		logic [3:0] channelMask;
		logic       halfReturnFlag;
		logic       shortDescriptorFlag;
		logic       unnormCoordFlag;
		logic [2:0] dimensionField;
		logic       lodWarnFlag;
		logic       residencyStatusFlag;
		logic       returnOrder;
		logic       levelZero;
		logic       depthCompare;
		logic       grad16;
	} iaru_flags_t;

	typedef struct packed {
		logic [63:0]      ptr;
		logic [31:0]      extent;
		logic [2:0][31:0] org;
		logic [2:0][31:0] dir;
		logic [2:0][31:0] inv;
	} iaru_ray_t;

	// address register counts per ray form
	localparam logic [3:0] RAY32_FULL = 4'hB;
	localparam logic [3:0] RAY32_HALF = 4'h8;
	localparam logic [3:0] RAY64_FULL = 4'hC;
	localparam logic [3:0] RAY64_HALF = 4'h9;
	localparam logic [3:0] RAY_CHMASK = 4'hF;
	localparam logic [2:0] DIM_1D     = 3'h0;
	// node and result encodings
	localparam int          NODE_TRI_BIT = 0;
	localparam logic [31:0] MISS_PTR     = 32'hFFFFFFFF;
	localparam logic [31:0] INF_TIME     = 32'h7F800000;
	localparam logic [31:0] ONE_F        = 32'h3F800000;
	localparam logic signed [9:0] F32_BIAS = 10'sh07F;
	localparam logic signed [9:0] F16_BIAS = 10'sh00F;
	// memory map, in words
	localparam int MEM_DEPTH    = 512;
	localparam int MSAA_BASE    = 128;
	localparam int TEX_BASE     = 256;
	localparam int LEVEL_STRIDE = 64;
	localparam int TEX_LOG2W    = 3;
	localparam int MIP_LEVELS   = 4;
endpackage
`default_nettype wire

//--- tb/iaru_monitor.sv
/*
 checker on the link between the shader core end and the operand unit.
 assumes: tb instantiates it beside the interface, one clock domain.
*/
`default_nettype none
module iaru_monitor (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  reset,
	// link signals
	input wire logic                  reqValid,
	input wire logic                  reqReady,
	input wire iaru_pkg::iaru_op_t    op,
	input wire iaru_pkg::iaru_flags_t flags,
	input wire logic [3:0]            addrCount,
	input wire logic [11:0][31:0]     addrVec,
	input wire logic                  rspValid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic isRay;
	wire logic is64;
	assign is64 = reqValid && op == iaru_pkg::OP_RAY64;
	assign isRay = is64 || (reqValid && op == iaru_pkg::OP_RAY32);

	take_answer_a: assert property (
		reqValid && reqReady |=> rspValid)
		else $error("no answer one cycle after a take");
	answer_cause_a: assert property (
		rspValid |-> $past(reqValid && reqReady))
		else $error("answer without a take");
	single_flight_a: assert property (
		rspValid |-> !reqValid)
		else $error("request present beside an answer");
	req_hold_a: assert property (
		reqValid && !reqReady |=> reqValid && $stable(addrVec)
			&& $stable(op))
		else $error("request changed while refused");
	ray_mask_a: assert property (
		isRay |-> flags.channelMask == iaru_pkg::RAY_CHMASK
			&& !flags.halfReturnFlag && flags.shortDescriptorFlag)
		else $error("ray mask or descriptor flags wrong");
	ray_flags_a: assert property (
		isRay |-> flags.unnormCoordFlag && !flags.lodWarnFlag
			&& flags.dimensionField == iaru_pkg::DIM_1D
			&& !flags.residencyStatusFlag)
		else $error("ray coordinate flags wrong");
	ray32_count_a: assert property (
		isRay && !is64 |-> addrCount == (flags.halfAddressFlag ?
			iaru_pkg::RAY32_HALF : iaru_pkg::RAY32_FULL))
		else $error("short pointer ray register count wrong");
	ray64_count_a: assert property (
		is64 |-> addrCount == (flags.halfAddressFlag ?
			iaru_pkg::RAY64_HALF : iaru_pkg::RAY64_FULL))
		else $error("long pointer ray register count wrong");

	cover property (isRay && reqReady);
	cover property (reqValid && !reqReady);
	cover property (reqValid && reqReady && op == iaru_pkg::OP_WRAP_DEC);
endmodule
`default_nettype wire

//--- tb/tb.sv
/*
 self-checking bench joining core end and unit end over the link.
 assumes: unit memory is loaded only through the fill port.
*/
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk;
	logic                  reset;
	logic                  cmdValid;
	logic                  cmdReady;
	logic                  resValid;
	logic                  memFillEn;
	logic                  rayValid;
	logic [31:0]           memFillAddr;
	logic [31:0]           memFillData;
	logic [31:0]           cmdData;
	iaru_pkg::iaru_op_t    cmdOp;
	iaru_pkg::iaru_flags_t cmdFlags;
	logic [3:0][31:0]      cmdAddr;
	logic [3:0][31:0]      resData;
	iaru_pkg::iaru_ray_t   cmdRay;
	iaru_pkg::iaru_ray_t   rayOut;
	int                    err_count = 0;
	int                    n_compared = 0;
	int                    nRay = 0;

	iaru_if lnk();
	iaru_device u_iaru_device (.clk(clk), .reset(reset), .link(lnk.dev),
		.memFillEn(memFillEn), .memFillAddr(memFillAddr),
		.memFillData(memFillData), .rayValid(rayValid), .rayOut(rayOut));
	iaru_core u_iaru_core (.clk(clk), .reset(reset), .link(lnk.core),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdFlags(cmdFlags), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.cmdRay(cmdRay), .resValid(resValid), .resData(resData));
	iaru_monitor u_mon (.clk(clk), .reset(reset),
		.reqValid(lnk.reqValid), .reqReady(lnk.reqReady), .op(lnk.op),
		.flags(lnk.flags), .addrCount(lnk.addrCount),
		.addrVec(lnk.addrVec), .rspValid(lnk.rspValid));

	always #10 clk = ~clk;

	// ray answers raise their pulse once each; count them at the edge
	always @(posedge clk)
		if (rayValid === 1'b1)
			nRay++;

	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// fill holds the memory port n cycles, refusing requests meanwhile
	task automatic fill(input logic [31:0] a, d, input int n = 1);
		@(posedge clk);
		memFillEn <= 1'b1;
		memFillAddr <= a;
		memFillData <= d;
		repeat (n) @(posedge clk);
		memFillEn <= 1'b0;
	endtask

	task automatic issue(input iaru_pkg::iaru_op_t o,
		input iaru_pkg::iaru_flags_t f, input logic [3:0][31:0] a,
		input logic [31:0] d = 32'h0,
		input iaru_pkg::iaru_ray_t r = '0);
		int i;
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdOp <= o;
		cmdFlags <= f;
		cmdAddr <= a;
		cmdData <= d;
		cmdRay <= r;
		@(posedge clk);
		cmdValid <= 1'b0;
		for (i = 0; i < 16 && resValid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (resValid !== 1'b1) begin
			err_count++;
			conclude();
		end
		check("cmd ready", 32'(cmdReady), 32'h1);
	endtask

	task automatic t_atomic;
		iaru_pkg::iaru_op_t op [9] = '{iaru_pkg::OP_CONJ,
			iaru_pkg::OP_DISJ, iaru_pkg::OP_EXCL, iaru_pkg::OP_WRAP_INC,
			iaru_pkg::OP_WRAP_INC, iaru_pkg::OP_WRAP_DEC,
			iaru_pkg::OP_WRAP_DEC, iaru_pkg::OP_WRAP_DEC, iaru_pkg::OP_DISJ};
		logic [31:0] dat [9] = '{32'h00FF, 32'h0F00, 32'h0FF0, 32'h00FF,
			32'h5, 32'h5, 32'h5, 32'h2, 32'h0};
		logic [31:0] old [9] = '{32'h0F0F, 32'h000F, 32'h0F0F, 32'h00FF,
			32'h0, 32'h1, 32'h0, 32'h5, 32'h2};
		fill(32'h0A, 32'h0F0F);
		foreach (op[i]) begin
			issue(op[i], '0, {96'h0, 32'h0A}, dat[i]);
			check("atomic old", resData[0], old[i]);
		end
		// fill owns the port first, so the increment must see its value
		fork
			fill(32'h0B, 32'h7, 3);
			issue(iaru_pkg::OP_WRAP_INC, '0, {96'h0, 32'h0B}, 32'hA);
		join
		check("blocked inc", resData[0], 32'h7);
		issue(iaru_pkg::OP_DISJ, '0, {96'h0, 32'h0B});
		check("inc stored", resData[0], 32'h8);
		$display("atomics done");
	endtask

	task automatic t_query;
		iaru_pkg::iaru_flags_t fl = '0;
		logic [31:0] w;
		for (int m = 0; m < 4; m++) begin
			issue(iaru_pkg::OP_RESINFO, '0, {96'h0, 32'(m)});
			w = m >= 3 ? 32'h1 : 32'h8 >> m;
			check("width", resData[0], w);
			check("height", resData[1], w);
			check("depth", resData[2], 32'h1);
			check("mips", resData[3], 32'(iaru_pkg::MIP_LEVELS));
		end
		for (int k = 0; k < 4; k++)
			fill(32'h84 + 32'(k), 32'hA0 + 32'(k));
		fl.channelMask = 4'hB;
		issue(iaru_pkg::OP_MSAA, fl, {32'h0, 32'h2, 32'h0, 32'h1});
		for (int i = 0; i < 4; i++)
			check("sample", resData[i], fl.channelMask[i] ?
				32'hA0 + 32'((2 + i) & 3) : 32'h0);
		$display("queries done");
	endtask

	task automatic t_ray;
		iaru_pkg::iaru_flags_t fl = '0;
		iaru_pkg::iaru_ray_t r = '0;
		logic [31:0] tm [4] = '{32'h5, 32'h2, 32'h9, 32'h2};
		for (int i = 0; i < 4; i++) begin
			fill(32'h14 + 32'(i), 32'h100 + 32'(i));
			fill(32'h18 + 32'(i), tm[i]);
		end
		fill(32'h28, 32'h6);
		fill(32'h29, 32'h55);
		// bad encoding bits on purpose: the core end overrides the dimension field; return order passes through
		fl.returnOrder = 1'b1;
		fl.dimensionField = 3'h5;
		r.ptr = 64'h14;
		r.extent = 32'h8;
		issue(iaru_pkg::OP_RAY32, fl, '0, 32'h0, r);
		check("box 0", resData[0], 32'h101);
		check("box 1", resData[1], 32'h103);
		check("box 2", resData[2], 32'h100);
		check("box 3", resData[3], 32'hFFFFFFFF);
		r.dir[1] = 32'h1234ABCD;
		r.inv[1] = 32'h56784321;
		for (int k = 0; k < 8; k++) begin
			fl.halfAddressFlag = k[0];
			fl.nonseqAddressMode = k[1];
			r.ptr = {32'(k), 32'h29};
			r.extent = k[0] ? 32'h6 : 32'h5;
			issue(k[2] ? iaru_pkg::OP_RAY64 : iaru_pkg::OP_RAY32, fl, '0,
				32'h0, r);
			check("tri time", resData[0],
				k[0] ? 32'h6 : iaru_pkg::INF_TIME);
			check("tri id", resData[1], 32'h55);
			check("extent", rayOut.extent, r.extent);
			check("dir", rayOut.dir[1],
				k[0] ? 32'hABCD : 32'h1234ABCD);
			check("inv", rayOut.inv[1],
				k[0] ? 32'h4321 : 32'h56784321);
			if (k[2])
				check("ptr hi", rayOut.ptr[63:32], 32'(k));
		end
		check("ray pulses", 32'(nRay), 32'h9);
		$display("ray tests done");
	endtask

	task automatic t_tex;
		iaru_pkg::iaru_flags_t fl = '0;
		logic [31:0] g [3] = '{32'h41800000, 32'h3C00, 32'h3E000000};
		logic [31:0] cl [3] = '{32'h40400000, 32'h0, 32'h0};
		logic [31:0] rw [3] = '{32'h40800000, 32'h0, 32'hC0400000};
		logic [31:0] tx [4] = '{32'h11, 32'h22, 32'h33, 32'h44};
		for (int i = 0; i < 3; i++) begin
			fl.levelZero = i == 0;
			fl.grad16 = i == 1;
			issue(iaru_pkg::OP_LOD, fl, {32'h0, g[i], 64'h0});
			check("clamped", resData[0], cl[i]);
			check("raw", resData[1], rw[i]);
		end
		fill(32'h10A, tx[0]);
		fill(32'h10B, tx[1]);
		fill(32'h112, tx[2]);
		fill(32'h113, tx[3]);
		fill(32'h146, 32'h66);
		fl = '0;
		issue(iaru_pkg::OP_GATHER, fl, {32'h0, 32'h0, 32'h1, 32'h2});
		for (int q = 0; q < 4; q++)
			check("gather", resData[q], tx[q]);
		fl.depthCompare = 1'b1;
		issue(iaru_pkg::OP_GATHER, fl, {32'h22, 32'h0, 32'h1, 32'h2});
		for (int q = 0; q < 4; q++)
			check("compare", resData[q],
				q < 2 ? iaru_pkg::ONE_F : 32'h0);
		fl = '0;
		fl.levelZero = 1'b1;
		issue(iaru_pkg::OP_SAMPLE, fl, {32'h0, g[0], 32'h1, 32'h2});
		check("level zero", resData[0], tx[0]);
		fl = '0;
		fl.grad16 = 1'b1;
		issue(iaru_pkg::OP_SAMPLE, fl, {32'h0, 32'h4000, 32'h1, 32'h2});
		check("half grad", resData[0], 32'h66);
		$display("texture tests done");
	endtask

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		cmdValid = 1'b0;
		cmdOp = iaru_pkg::OP_CONJ;
		cmdFlags = '0;
		cmdAddr = '0;
		cmdData = '0;
		cmdRay = '0;
		memFillEn = 1'b0;
		memFillAddr = '0;
		memFillData = '0;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_atomic();
		t_query();
		t_ray();
		t_tex();
		conclude();
	end
endmodule
`default_nettype wire
